// file: ser_params.svh
// Register map, field widths and reset values of the status event reporting block
`ifndef SER_PARAMS_SVH
`define SER_PARAMS_SVH
`define SER_REG_W          15
`define SER_ADDR_W         8
`define SER_OFF_ALM_COND   8'h00
`define SER_OFF_ALM_EVENT  8'h04
`define SER_OFF_ALM_ENABLE 8'h08
`define SER_OFF_OPR_COND   8'h10
`define SER_OFF_OPR_EVENT  8'h14
`define SER_OFF_OPR_ENABLE 8'h18
`define SER_OFF_QUE_COND   8'h20
`define SER_OFF_QUE_EVENT  8'h24
`define SER_OFF_QUE_ENABLE 8'h28
`define SER_OFF_CONTROL    8'h30
`define SER_CTRL_CLS_BIT   0
`define SER_CTRL_PRE_BIT   1
`define SER_CTRL_PSC_BIT   2
`define SER_ZERO_REG       15'h0000
`define SER_ZERO_WORD      32'h0000_0000
`define SER_PAD_W          17
`define SER_GROUPS         3
`endif

// file: ser_pkg.sv
// Types shared by the status event reporting block
package ser_pkg;
	typedef logic [14:0] ser_reg_t;
	typedef struct packed {
		ser_reg_t cond;
		ser_reg_t event_r;
		ser_reg_t enable;
	} ser_group_s;
endpackage : ser_pkg

// file: ser_status.sv
// Status event reporting: alarm, operation and questionable groups behind an APB slave
//
// Summary of operation
// (RULE_01) Condition registers follow the monitored inputs every cycle, without latching.
// (RULE_02) Condition registers are read-only; reading them changes nothing.
// (RULE_03) Every group register reads as 15 bits, value 0 to 32767.
// (RULE_04) Event registers latch condition events bit by bit as sticky flags.
// (RULE_05) A set event bit ignores further events on that bit.
// (RULE_06) Event bits clear on event register read or on clear-status.
// (RULE_07) Event registers ignore host writes.
// (RULE_08) Enable registers mask which event bits reach the summary.
// (RULE_09) Enable registers store and return any written 15-bit value.
// (RULE_10) Status preset clears all three enable registers.
// (RULE_11) Power-on clearing of enables depends on the stored power-on-clear setting.
// (RULE_12) Three independent groups, each with condition, event and enable registers.
// (RULE_13) Group summary is high when event AND enable is non-zero.
// (RULE_14) Event bit sets on the rising edge of its condition bit.
//
// A transfer takes one wait state: pready is a flop that rises the cycle after the
// first access-phase edge and stands for exactly one cycle.
// Condition pins are asynchronous and pass two flops before any logic reads them,
// so a pin change shows in its condition register on the third edge.
// Writes to condition and event words are accepted without error and have no effect.
// Reading an event word clears it in that access; a rising edge in that cycle is kept.
// The power-on-clear setting is not reset; software writes the control word first.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "ser_params.svh"

module ser_status (
	input  wire logic                   sys_clk,
	input  wire logic                   reset,
	input  wire logic [`SER_REG_W-1:0]  alm_cond_in,
	input  wire logic [`SER_REG_W-1:0]  opr_cond_in,
	input  wire logic [`SER_REG_W-1:0]  que_cond_in,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`SER_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	output logic                        alm_summary,
	output logic                        opr_summary,
	output logic                        que_summary
);

	// Condition pins: raw, first and second synchroniser stage, rising bits
	ser_pkg::ser_reg_t      raw_in       [`SER_GROUPS];
	ser_pkg::ser_reg_t      sync1        [`SER_GROUPS];
	ser_pkg::ser_reg_t      sync2        [`SER_GROUPS];
	ser_pkg::ser_reg_t      rise         [`SER_GROUPS];

	// Group registers and their next values
	ser_pkg::ser_group_s    grp          [`SER_GROUPS];
	ser_pkg::ser_group_s    next_grp     [`SER_GROUPS];
	logic [`SER_GROUPS-1:0] next_summary;

	// Address map, one entry per group
	logic [`SER_ADDR_W-1:0] off_cond     [`SER_GROUPS];
	logic [`SER_ADDR_W-1:0] off_event    [`SER_GROUPS];
	logic [`SER_ADDR_W-1:0] off_enable   [`SER_GROUPS];

	// Decoded register selects
	logic [`SER_GROUPS-1:0] sel_cond;
	logic [`SER_GROUPS-1:0] sel_event;
	logic [`SER_GROUPS-1:0] sel_enable;
	logic [`SER_GROUPS-1:0] sel_grp;
	logic                   sel_control;
	logic                   sel_any;

	// Bus qualifiers and decoded actions
	logic                   access;
	logic                   wr;
	logic                   rd;
	logic [`SER_GROUPS-1:0] rd_event;
	logic [`SER_GROUPS-1:0] wr_enable;
	logic                   wr_control;
	logic                   cls;
	logic                   preset;

	// Read data sources
	logic [31:0]            grp_word     [`SER_GROUPS];
	logic [31:0]            ctrl_word;
	logic [31:0]            rd_word;

	// Power-on-clear setting, bus answer and summary outputs
	logic                   psc;
	logic                   next_psc;
	logic [31:0]            next_prdata;
	logic                   next_pready;
	logic                   next_pslverr;
	logic                   next_alm_summary;
	logic                   next_opr_summary;
	logic                   next_que_summary;

	assign raw_in[0] = alm_cond_in;
	assign raw_in[1] = opr_cond_in;
	assign raw_in[2] = que_cond_in;

	assign off_cond[0]   = `SER_OFF_ALM_COND;
	assign off_event[0]  = `SER_OFF_ALM_EVENT;
	assign off_enable[0] = `SER_OFF_ALM_ENABLE;

	assign off_cond[1]   = `SER_OFF_OPR_COND;
	assign off_event[1]  = `SER_OFF_OPR_EVENT;
	assign off_enable[1] = `SER_OFF_OPR_ENABLE;

	assign off_cond[2]   = `SER_OFF_QUE_COND;
	assign off_event[2]  = `SER_OFF_QUE_EVENT;
	assign off_enable[2] = `SER_OFF_QUE_ENABLE;

	// Only the first access-phase cycle is taken: the registered pready
	// masks the second cycle of the same transfer, so nothing acts twice.
	assign access      = psel && penable && !pready;
	assign wr          = access && pwrite;
	assign rd          = access && !pwrite;
	assign sel_control = (paddr == `SER_OFF_CONTROL);
	assign wr_control  = wr && sel_control;
	assign cls         = wr_control && pwdata[`SER_CTRL_CLS_BIT];
	assign preset      = wr_control && pwdata[`SER_CTRL_PRE_BIT];
	assign sel_any     = (|sel_grp) || sel_control;

	genvar g;
	generate
		for (g = 0; g < `SER_GROUPS; g++) begin : gen_grp
			// Register selects of this group
			assign sel_cond[g]   = (paddr == off_cond[g]);
			assign sel_event[g]  = (paddr == off_event[g]);
			assign sel_enable[g] = (paddr == off_enable[g]);
			assign sel_grp[g]    = sel_cond[g] || sel_event[g] || sel_enable[g];

			// Accesses that change state in this group
			assign rd_event[g]   = rd && sel_event[g];
			assign wr_enable[g]  = wr && sel_enable[g];

			// A bit rises when the synchronised pin is high and the condition register still low
			assign rise[g]       = sync2[g] & ~grp[g].cond; // [RULE_14]

			// Two flops per pin; only the second stage feeds any logic
			always_ff @(posedge sys_clk) begin
				sync1[g] <= raw_in[g];
				sync2[g] <= sync1[g];
			end

			// Zero after reset: a condition already high then is seen as a new event
			always_comb begin
				next_grp[g].cond = sync2[g]; // [RULE_01]
				if (reset) begin
					next_grp[g].cond = `SER_ZERO_REG;
				end
			end

			always_ff @(posedge sys_clk) begin
				grp[g].cond <= next_grp[g].cond;
			end

			always_comb begin
				next_grp[g].event_r = grp[g].event_r;
				// Clear first, then new rising edges: an edge that meets the clear is kept
				if (cls || rd_event[g]) begin
					next_grp[g].event_r = `SER_ZERO_REG; // [RULE_06]
				end
				// Already-set bits just stay set, so repeats have no effect
				next_grp[g].event_r = next_grp[g].event_r | rise[g]; // [RULE_04] [RULE_05]
				if (reset) begin
					next_grp[g].event_r = `SER_ZERO_REG;
				end
			end

			always_ff @(posedge sys_clk) begin
				grp[g].event_r <= next_grp[g].event_r;
			end

			always_comb begin
				next_grp[g].enable = grp[g].enable;
				if (wr_enable[g]) begin
					next_grp[g].enable = pwdata[`SER_REG_W-1:0]; // [RULE_09]
				end
				if (preset) begin
					next_grp[g].enable = `SER_ZERO_REG; // [RULE_10]
				end
				// Enables survive reset unless the power-on-clear setting is on
				if (reset && psc) begin
					next_grp[g].enable = `SER_ZERO_REG; // [RULE_11]
				end else if (reset) begin
					next_grp[g].enable = grp[g].enable; // [RULE_11]
				end
			end

			always_ff @(posedge sys_clk) begin
				grp[g].enable <= next_grp[g].enable;
			end

			// Built from next values so the summary moves on the same edge as the event bit
			always_comb begin
				next_summary[g] = |(next_grp[g].event_r & next_grp[g].enable); // [RULE_08] [RULE_13]
			end

			// Read word of this group; the three selects never overlap
			always_comb begin
				grp_word[g] = `SER_ZERO_WORD;
				if (sel_cond[g]) begin
					grp_word[g] = {{`SER_PAD_W{1'h0}}, grp[g].cond}; // [RULE_02] [RULE_03]
				end
				if (sel_event[g]) begin
					grp_word[g] = {{`SER_PAD_W{1'h0}}, grp[g].event_r}; // [RULE_03]
				end
				if (sel_enable[g]) begin
					grp_word[g] = {{`SER_PAD_W{1'h0}}, grp[g].enable}; // [RULE_03]
				end
			end
		end
	endgenerate

	// Action bits are pulses and read back as zero; only the stored setting shows
	always_comb begin
		ctrl_word                    = `SER_ZERO_WORD;
		ctrl_word[`SER_CTRL_PSC_BIT] = psc;
	end

	// Selects are exclusive, so OR-ing the sources forms the read mux
	always_comb begin
		rd_word = `SER_ZERO_WORD;
		if (sel_control) begin
			rd_word = ctrl_word;
		end
		for (int s = 0; s < `SER_GROUPS; s++) begin
			rd_word = rd_word | grp_word[s];
		end
	end

	always_comb begin
		next_psc = psc;
		if (wr_control) begin
			next_psc = pwdata[`SER_CTRL_PSC_BIT];
		end
	end

	// Stands for a nonvolatile bit: reset leaves it alone, so its power-up
	// value is unknown until software writes the control word.
	always_ff @(posedge sys_clk) begin
		psc <= next_psc;
	end

	// The answer strobe: one cycle high per taken access
	always_comb begin
		next_pready = 1'h0;
		if (!reset && access) begin
			next_pready = 1'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		pready <= next_pready;
	end

	// Unmapped addresses answer with an error and zero data
	always_comb begin
		next_pslverr = 1'h0;
		if (!reset && access && !sel_any) begin
			next_pslverr = 1'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		pslverr <= next_pslverr;
	end

	// Write answers return zero; condition and event writes are dropped [RULE_02] [RULE_07]
	always_comb begin
		next_prdata = `SER_ZERO_WORD;
		if (!reset && rd && sel_any) begin
			next_prdata = rd_word; // [RULE_12]
		end
	end

	always_ff @(posedge sys_clk) begin
		prdata <= next_prdata;
	end

	always_comb begin
		next_alm_summary = next_summary[0];
		next_opr_summary = next_summary[1];
		next_que_summary = next_summary[2];
		if (reset) begin
			next_alm_summary = 1'h0;
			next_opr_summary = 1'h0;
			next_que_summary = 1'h0;
		end
	end

	// The summary outputs come straight from these flops
	always_ff @(posedge sys_clk) begin
		alm_summary <= next_alm_summary;
		opr_summary <= next_opr_summary;
		que_summary <= next_que_summary;
	end
endmodule : ser_status

// file: ser_status_monitor.sv
// Checker for the APB side and summary outputs
`timescale 1ns/1ps
module ser_status_monitor (
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        alm_summary,
	input wire logic        opr_summary,
	input wire logic        que_summary
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence s_req; psel && penable && !pready; endsequence
	property p_pulse; pready |=> !pready; endproperty
	property p_answer; s_req |=> pready; endproperty
	property p_cause; pready |-> $past(psel) && $past(penable); endproperty
	property p_err; s_req ##0 paddr == 8'hfc |=> pslverr; endproperty
	property p_noerr; s_req ##0 paddr == 8'h28 |=> !pslverr; endproperty
	property p_upper; pready |-> prdata[31:15] == 17'h00000; endproperty
	property p_errpair; pslverr |-> pready; endproperty
	property p_preset; s_req ##0 pwrite && paddr == 8'h30 && pwdata[1] |=> ##1 !(alm_summary | opr_summary | que_summary);
	endproperty
	a_pulse: assert property (p_pulse) else $error("pready held too long");
	a_answer: assert property (p_answer) else $error("no answer");
	a_cause: assert property (p_cause) else $error("pready without access");
	a_err: assert property (p_err) else $error("no error on unmapped");
	a_noerr: assert property (p_noerr) else $error("error on mapped");
	a_upper: assert property (p_upper) else $error("upper bits set");
	a_errpair: assert property (p_errpair) else $error("stray pslverr");
	a_preset: assert property (p_preset) else $error("summary after preset");
endmodule : ser_status_monitor
bind ser_status ser_status_monitor mon_i (.*);

// file: ser_cond_src.sv
// Condition source standing for the monitored instrument state
`timescale 1ns/1ps
module ser_cond_src (
	input  wire logic        sys_clk,
	input  wire logic [44:0] want,
	output logic      [14:0] alm,
	output logic      [14:0] opr,
	output logic      [14:0] que
);
	// Registered so every change lands clock-aligned
	always_ff @(posedge sys_clk) begin
		{alm, opr, que} <= want;
	end
endmodule : ser_cond_src

// file: ser_status_tb.sv
// Testbench for the status event reporting block
`timescale 1ns/1ps
module ser_status_tb;
	logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr, err;
	logic        alm_summary, opr_summary, que_summary;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [14:0] alm_cond_in, opr_cond_in, que_cond_in;
	logic [44:0] want;
	int          n_mismatch, comparisons, i;
	logic [14:0] en [3] = '{15'h7fff, 15'h4a5a, 15'h0001};
	logic [14:0] cv [3] = '{15'h0010, 15'h1000, 15'h0002};
	ser_status ser_status_i (.*);
	ser_cond_src ser_cond_src_i (.sys_clk(sys_clk), .want(want), .alm(alm_cond_in), .opr(opr_cond_in), .que(que_cond_in));
	task automatic wrap_up();
		if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge sys_clk) penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rdat = prdata; err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge sys_clk);
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask : rd
	task automatic rst();
		reset <= 1'b1;
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
	endtask : rst
	initial begin
		sys_clk = 0;
		forever #20 sys_clk = ~sys_clk;
	end
	initial begin
		#200000 n_mismatch++;
		wrap_up();
	end
	initial begin
		{reset, psel, penable, pwrite, paddr, pwdata, want} = '0;
		@(posedge sys_clk) rst();
		xfer(1'b1, 8'h30, 32'h4);
		for (i = 0; i < 3; i++) begin
			xfer(1'b1, 8'h08 + 8'(16 * i), 32'(en[i]));
			rd(8'h08 + 8'(16 * i), 32'(en[i]));
		end
		xfer(1'b1, 8'h04, 32'h7fff);
		rd(8'h04, 32'h0);
		want <= {cv[0], cv[1], cv[2]};
		repeat (6) @(posedge sys_clk);
		chk({29'h0, alm_summary, opr_summary, que_summary}, 32'h4);
		for (i = 0; i < 3; i++) begin
			rd(8'h00 + 8'(16 * i), 32'(cv[i]));
			rd(8'h00 + 8'(16 * i), 32'(cv[i]));
			rd(8'h04 + 8'(16 * i), 32'(cv[i]));
			rd(8'h04 + 8'(16 * i), 32'h0);
		end
		want <= '0;
		repeat (6) @(posedge sys_clk);
		want <= {cv[0], cv[1], cv[2]};
		repeat (6) @(posedge sys_clk);
		xfer(1'b1, 8'h30, 32'h5);
		rd(8'h04, 32'h0);
		xfer(1'b1, 8'h30, 32'h6);
		rd(8'h08, 32'h0);
		rd(8'hfc, 32'h0);
		chk({31'h0, err}, 32'h1);
		want <= '0;
		xfer(1'b1, 8'h08, 32'h0123);
		xfer(1'b1, 8'h30, 32'h0);
		rst();
		rd(8'h08, 32'h0123);
		xfer(1'b1, 8'h30, 32'h4);
		rst();
		rd(8'h08, 32'h0);
		wrap_up();
	end
endmodule : ser_status_tb
